// File: core/spa_arbiter.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - nine request pins plus internal request
// - each request configurable high or low group
// - at most one grant asserted
// - two-level rotating priority selects winner
// - internal request and grant stay off the pins while the arbiter is enabled
// - strap low enables, high disables arbiter
// - request pin zero becomes grant input
// - grant pin zero becomes request output
// - park when granted, idle, not needed
// - parity driven one cycle after parking
module spa_arbiter (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire spa_pkg::spa_wb_req_t wb_req_i,
	output spa_pkg::spa_wb_rsp_t wb_rsp_o,
	// secondary arbitration pins
	input wire logic [8:0] req_pin_n_i,
	output logic [8:0] gnt_pin_n_o,
	output logic [8:0] gnt_pin_oe_n_o,
	input wire logic cfn_pin_n_i,
	// secondary bus state pins
	input wire spa_pkg::spa_bus_t bus_i,
	// bridge initiator side
	input wire logic own_req_i,
	output logic own_gnt_o,
	// parking drive enables
	output logic ad_park_o,
	output logic par_park_o
);

	localparam int N = spa_pkg::NUM_MASTERS;

	// ****************************************************************
	// pin synchronisers (three stages, second and third must agree)
	// ****************************************************************
	logic [N-1:0] req_s1_reg, req_s2_reg, req_s3_reg, req_reg;
	logic [1:0] fb_s1_reg, fb_s2_reg, fb_s3_reg, fb_reg;
	logic cfn_s1_reg, cfn_s2_reg, cfn_s3_reg;
	logic ext_mode_reg;
	logic strap_taken_reg;
	logic [1:0] fill_reg;
	logic strap_ready;
	logic [N-1:0] req_next;
	logic [1:0] fb_next;

	assign req_next = (req_s2_reg == req_s3_reg) ? ~req_s3_reg : req_reg;
	assign fb_next = (fb_s2_reg == fb_s3_reg) ? ~fb_s3_reg : fb_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_s1_reg <= {N{1'b1}};
			req_s2_reg <= {N{1'b1}};
			req_s3_reg <= {N{1'b1}};
			req_reg <= '0;
			fb_s1_reg <= 2'h3;
			fb_s2_reg <= 2'h3;
			fb_s3_reg <= 2'h3;
			fb_reg <= 2'h0;
			cfn_s1_reg <= 1'b0;
			cfn_s2_reg <= 1'b0;
			cfn_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_pin_n_i;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			req_reg <= req_next;
			fb_s1_reg <= {bus_i.frame_n, bus_i.irdy_n};
			fb_s2_reg <= fb_s1_reg;
			fb_s3_reg <= fb_s2_reg;
			fb_reg <= fb_next;
			cfn_s1_reg <= cfn_pin_n_i;
			cfn_s2_reg <= cfn_s1_reg;
			cfn_s3_reg <= cfn_s2_reg;
		end
	end

	// strap is a static level: latched once the chain holds real pin samples,
	// never the values that reset left in it
	assign strap_ready = (&fill_reg) && (cfn_s2_reg == cfn_s3_reg) && (req_s3_reg == req_s2_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_reg <= 2'h0;
			strap_taken_reg <= 1'b0;
			ext_mode_reg <= 1'b0;
		end else begin
			fill_reg <= fill_reg + {1'b0, !(&fill_reg)};
			if (!strap_taken_reg && strap_ready) begin
				strap_taken_reg <= 1'b1;
				ext_mode_reg <= cfn_s3_reg;
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [N:0] prio_reg, prio_next;
	logic force_idle_reg, force_idle_next;
	logic ack_reg;
	logic [31:0] rdat_reg, rdat_next;
	logic wb_hit;
	logic wb_wr;
	logic [31:0] status_word;

	assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
	// write lands on the edge at which the master samples ack
	assign wb_wr = wb_req_i.cyc && wb_req_i.stb && ack_reg && wb_req_i.we && wb_req_i.sel[0];

	// ****************************************************************
	// bus idle and arbitration
	// ****************************************************************
	logic bus_idle;
	logic arb_on;
	logic [N-1:0] hi_req, lo_req, hi_pick, lo_pick;
	logic lo_slot_req;
	logic [N:0] top_req, top_pick;
	logic [N:0] gnt_reg, gnt_next;
	logic [N:0] winner;
	logic advance;
	logic busy_start;
	logic idle_prev_reg;
	logic int_req_hi;

	assign bus_idle = fb_reg == 2'h0;
	assign arb_on = strap_taken_reg && !ext_mode_reg && !force_idle_reg;
	// bit N is the bridge's own internal request
	assign int_req_hi = own_req_i && !prio_reg[spa_pkg::PRIO_GRP_INT_POS];
	assign hi_req = req_reg & ~prio_reg[N-1:0];
	assign lo_req = req_reg & prio_reg[N-1:0];
	assign lo_slot_req = (|lo_req) || (own_req_i && prio_reg[spa_pkg::PRIO_GRP_INT_POS]);
	// the low group takes slot 0 of the top rotation; internal rides slot per group
	assign top_req = {int_req_hi, hi_req[N-1:1], hi_req[0] | lo_slot_req};
	// rotate once the granted master has taken the bus; the grant then moves on
	// while it finishes, so the pin latency never hands it a second turn
	assign busy_start = idle_prev_reg && !bus_idle;
	assign advance = arb_on && busy_start;

	spa_rr_pick #(.N(N + 1)) u_top (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(top_req),
		.advance_i(advance),
		.pick_o(top_pick),
		.any_o()
	);

	spa_rr_pick #(.N(N)) u_low (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(lo_req),
		.advance_i(advance && top_pick[0] && !hi_req[0]),
		.pick_o(lo_pick),
		.any_o()
	);

	assign hi_pick = top_pick[N-1:0];
	// slot 0 goes to master 0 if high, else to the low group's winner
	assign winner = top_pick[0] ? (hi_req[0] ? {1'b0, {(N-1){1'b0}}, 1'b1} :
		((|lo_req) ? {1'b0, lo_pick} : {1'b1, {N{1'b0}}})) : top_pick;
	assign gnt_next = !arb_on ? '0 : winner;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gnt_reg <= '0;
			idle_prev_reg <= 1'b1;
		end else begin
			gnt_reg <= gnt_next;
			idle_prev_reg <= bus_idle;
		end
	end

	// ****************************************************************
	// external arbiter mode and parking
	// ****************************************************************
	logic ext_gnt;
	logic park_reg, park_next;
	logic par_reg;
	logic own_req_reg;

	assign ext_gnt = req_reg[0];
	assign park_next = ext_mode_reg && strap_taken_reg && ext_gnt && bus_idle && !own_req_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			park_reg <= 1'b0;
			par_reg <= 1'b0;
			own_req_reg <= 1'b0;
		end else begin
			park_reg <= park_next;
			// parity trails the address drive by one cycle, on and off
			par_reg <= park_reg;
			own_req_reg <= own_req_i;
		end
	end

	// internal grant never leaves the block through a pin
	assign own_gnt_o = ext_mode_reg ? (ext_gnt && bus_idle) : gnt_reg[N];
	assign ad_park_o = park_reg;
	assign par_park_o = par_reg;

	// grant pins: pin 0 doubles as request output in external mode
	logic [N-1:0] gnt_pin_n;
	assign gnt_pin_n[N-1:1] = ext_mode_reg ? {(N-1){1'b1}} : ~gnt_reg[N-1:1];
	assign gnt_pin_n[0] = ext_mode_reg ? !own_req_reg : !gnt_reg[0];
	assign gnt_pin_n_o = gnt_pin_n;
	// unused grants float in external mode; pull-ups hold them high
	assign gnt_pin_oe_n_o = ext_mode_reg ? {{(N-1){1'b1}}, 1'b0} : {N{1'b0}};

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	assign status_word = {19'h0, ext_mode_reg, park_reg, ext_mode_reg, gnt_reg[N], gnt_reg[N-1:0]};
	assign prio_next = (wb_wr && wb_req_i.adr[7:0] == spa_pkg::ADDR_PRIO) ?
		{wb_req_i.dat[9:8] & {wb_req_i.sel[1], wb_req_i.sel[1]}, wb_req_i.dat[7:0]} |
		{prio_reg[N:N-1] & {!wb_req_i.sel[1], !wb_req_i.sel[1]}, 8'h00} : prio_reg;
	assign force_idle_next = (wb_wr && wb_req_i.adr[7:0] == spa_pkg::ADDR_CTRL) ?
		wb_req_i.dat[spa_pkg::CTRL_FORCE_IDLE_POS] : force_idle_reg;

	always_comb begin
		rdat_next = 32'h0000_0000;
		case (wb_req_i.adr[7:0])
			spa_pkg::ADDR_PRIO: begin
				rdat_next = {22'h0, prio_reg};
			end
			spa_pkg::ADDR_STATUS: begin
				rdat_next = status_word;
			end
			spa_pkg::ADDR_CTRL: begin
				rdat_next = {31'h0, force_idle_reg};
			end
			default: begin
				rdat_next = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prio_reg <= spa_pkg::PRIO_RESET;
			force_idle_reg <= spa_pkg::CTRL_RESET;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			prio_reg <= prio_next;
			force_idle_reg <= force_idle_next;
			ack_reg <= wb_hit;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_rsp_o.ack = ack_reg;
	assign wb_rsp_o.dat = rdat_reg;

endmodule

`default_nettype wire

// File: core/spa_pkg.sv
package spa_pkg;

	// ****************************************************************
	// register map (byte offsets on classic wishbone, 32-bit data)
	// ****************************************************************
	localparam logic [7:0] ADDR_PRIO = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int PRIO_GRP_INT_POS = 9;
	localparam logic [9:0] PRIO_RESET = 10'h000;
	localparam int STAT_GNT_POS = 0;
	localparam int STAT_IGNT_POS = 9;
	localparam int STAT_EXT_POS = 10;
	localparam int STAT_PARK_POS = 11;
	localparam int STAT_OWNER_POS = 12;
	localparam int CTRL_FORCE_IDLE_POS = 0;
	localparam logic [0:0] CTRL_RESET = 1'h0;
	localparam int NUM_MASTERS = 9;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} spa_wb_req_t;

	typedef struct packed {
		logic [31:0] dat;
		logic ack;
	} spa_wb_rsp_t;

	typedef struct packed {
		logic frame_n;
		logic irdy_n;
	} spa_bus_t;

endpackage

// File: core/spa_rr_pick.sv
`timescale 1ns/10ps
`default_nettype none

// rotating picker: the bit just past last winner has top priority
module spa_rr_pick #(
	parameter int N = 9
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request side
	input wire logic [N-1:0] req_i,
	input wire logic advance_i,
	// result
	output logic [N-1:0] pick_o,
	output logic any_o
);

	logic [N-1:0] last_reg;
	logic [N-1:0] last_next;
	logic [2*N-1:0] dbl;
	logic [2*N-1:0] mask_hi;
	logic [2*N-1:0] sel_dbl;
	logic [N-1:0] pick;

	// ****************************************************************
	// rotation
	// ****************************************************************
	// lower-bit mask of the last winner, doubled so the wrap needs no loop
	assign dbl = {req_i, req_i} & ~mask_hi;
	assign mask_hi = {{N{1'b0}}, (last_reg - 1'b1) | last_reg};
	assign sel_dbl = dbl & (~dbl + 1'b1);
	assign pick = sel_dbl[N-1:0] | sel_dbl[2*N-1:N];
	assign pick_o = pick;
	assign any_o = |req_i;
	// most recent winner drops to lowest priority
	assign last_next = (advance_i && (|pick)) ? pick : last_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_reg <= {1'b1, {(N-1){1'b0}}};
		end else begin
			last_reg <= last_next;
		end
	end

endmodule

`default_nettype wire

// File: bench/spa_arbiter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker
// ****
module spa_arbiter_monitor (
	// clock, reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched pins
	input wire logic [8:0] req_pin_n_i,
	input wire logic [8:0] gnt_pin_n_o,
	input wire logic [8:0] gnt_pin_oe_n_o,
	input wire logic cfn_pin_n_i,
	input wire logic own_req_i,
	input wire logic own_gnt_o,
	input wire logic ad_park_o,
	input wire logic par_park_o
);
	// strap is latched a few edges after reset
	logic [3:0] up_reg;
	logic [3:0] hi_reg;
	wire logic ok = &up_reg;
	wire logic ex = cfn_pin_n_i;
	always_ff @(posedge clk_i) begin
		up_reg <= rst_i ? 4'h0 : up_reg + {3'h0, !ok};
		hi_reg <= (rst_i || !req_pin_n_i[0]) ? 4'h0 : hi_reg + {3'h0, !(&hi_reg)};
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_one; ok && !ex |-> $onehot0(~gnt_pin_n_o); endproperty
	a_one: assert property (p_one) else $error("two grants");
	property p_hide; ok && !ex && own_gnt_o |-> &gnt_pin_n_o; endproperty
	a_hide: assert property (p_hide) else $error("own grant on pin");
	property p_dir; ok |-> gnt_pin_oe_n_o == (ex ? 9'h1FE : 9'h000); endproperty
	a_dir: assert property (p_dir) else $error("pin direction");
	property p_rqo; ok && ex |=> gnt_pin_n_o[0] == !$past(own_req_i); endproperty
	a_rqo: assert property (p_rqo) else $error("request out");
	property p_gin; ok && ex && hi_reg > 4'h5 |-> !own_gnt_o; endproperty
	a_gin: assert property (p_gin) else $error("grant in");
	property p_busy; ok && own_req_i && $past(own_req_i) && $past(own_req_i, 2) |-> !ad_park_o; endproperty
	a_busy: assert property (p_busy) else $error("parked while needed");
	property p_pon; $rose(ad_park_o) |=> $rose(par_park_o); endproperty
	a_pon: assert property (p_pon) else $error("parity on");
	property p_pof; $fell(ad_park_o) |=> $fell(par_park_o); endproperty
	a_pof: assert property (p_pof) else $error("parity off");
endmodule
bind spa_arbiter spa_arbiter_monitor spa_arbiter_monitor_inst (.clk_i, .rst_i, .req_pin_n_i, .gnt_pin_n_o,
	.gnt_pin_oe_n_o, .cfn_pin_n_i, .own_req_i, .own_gnt_o, .ad_park_o, .par_park_o);
`default_nettype wire

// File: bench/spa_masters.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// secondary masters
// ****
module spa_masters (
	// clock
	input wire logic clk_i,
	// wishes, grants
	input wire logic [8:0] want_i,
	input wire logic [8:0] gnt_n_i,
	// pins and starts
	output logic [8:0] req_n_o,
	output spa_pkg::spa_bus_t bus_o,
	output logic go_o,
	output logic [3:0] who_o
);
	// a transfer outlasts the arbiter's pin latency, so it can re-arbitrate
	logic [3:0] c_reg = 4'h0;
	wire logic [8:0] hit = want_i & ~gnt_n_i;
	// request held low as long as wanted
	assign req_n_o = ~want_i;
	// pull-ups return released lines high
	assign bus_o = {c_reg > 4'h3, c_reg > 4'h1} ^ 2'b11;
	initial go_o = 1'b0;
	always @(posedge clk_i) begin
		go_o <= c_reg == 4'h0 && hit != 9'h0;
		who_o <= 4'($clog2(hit));
		c_reg <= c_reg != 4'h0 ? c_reg - 4'h1 : (hit != 9'h0 ? 4'hB : 4'h0);
	end
endmodule
`default_nettype wire

// File: bench/spa_arbiter_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module spa_arbiter_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cfn = 1'b0;
	logic own_req = 1'b0;
	logic [8:0] want = 9'h000;
	spa_pkg::spa_wb_req_t wb = '0;
	spa_pkg::spa_wb_rsp_t rsp;
	spa_pkg::spa_bus_t bus;
	logic [8:0] rq_n, gnt_n, oe_n;
	logic own_gnt, ad, par, go;
	logic [3:0] who;
	logic [31:0] q;
	int miscompares = 0;
	int compares = 0;
	spa_arbiter spa_arbiter_inst (.clk_i, .rst_i, .wb_req_i(wb), .wb_rsp_o(rsp), .req_pin_n_i(rq_n),
		.gnt_pin_n_o(gnt_n), .gnt_pin_oe_n_o(oe_n), .cfn_pin_n_i(cfn), .bus_i(bus), .own_req_i(own_req),
		.own_gnt_o(own_gnt), .ad_park_o(ad), .par_park_o(par));
	spa_masters spa_masters_inst (.clk_i, .want_i(want), .gnt_n_i(gnt_n), .req_n_o(rq_n), .bus_o(bus),
		.go_o(go), .who_o(who));
	initial forever #5 clk_i = ~clk_i;
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb <= '{adr: {24'h0, a}, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
		@(posedge clk_i);
		while (rsp.ack !== 1'b1)
			@(posedge clk_i);
		q = rsp.dat;
		wb <= '0;
		@(posedge clk_i);
	endtask
	task automatic reset_to(input logic s);
		rst_i <= 1'b1;
		cfn <= s;
		want <= 9'h000;
		own_req <= 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (16) @(posedge clk_i);
	endtask
	task automatic next_go();
		@(posedge clk_i);
		for (int n = 0; n < 99 && go !== 1'b1; n++)
			@(posedge clk_i);
	endtask
	task automatic t_regs();
		op(1'b1, 8'h0C, 32'hFFFFFFFF);
		op(1'b0, 8'h0C, 32'h0);
		chk("hole", 32'h0, q);
		op(1'b1, spa_pkg::ADDR_PRIO, 32'h3FF);
		op(1'b0, spa_pkg::ADDR_PRIO, 32'h0);
		chk("prio", 32'h3FF, q);
		$display("regs done");
	endtask
	task automatic t_lone();
		for (int i = 0; i < 9; i++) begin
			want <= 9'h1 << i;
			for (int n = 0; n < 60 && gnt_n[i] !== 1'b0; n++)
				@(posedge clk_i);
			chk("grant", {23'h0, ~(9'h1 << i)}, 32'(gnt_n));
			want <= 9'h000;
			repeat (20) @(posedge clk_i);
		end
		$display("lone done");
	endtask
	task automatic t_share();
		int c[9] = '{default: 0};
		logic [3:0] p;
		op(1'b1, spa_pkg::ADDR_PRIO, 32'h00A);
		want <= 9'h00E;
		for (int k = 0; k < 8; k++) begin
			next_go();
			c[who]++;
		end
		chk("high share", 4, c[2]);
		chk("low share", 2, c[3]);
		chk("low share", 2, c[1]);
		op(1'b1, spa_pkg::ADDR_PRIO, 32'h0);
		next_go();
		for (int k = 0; k < 6; k++) begin
			p = who;
			next_go();
			chk("rotate", (p == 4'h3) ? 32'h1 : 32'(p + 4'h1), 32'(who));
		end
		want <= 9'h000;
		repeat (20) @(posedge clk_i);
		$display("share done");
	endtask
	task automatic t_own();
		own_req <= 1'b1;
		for (int n = 0; n < 60 && own_gnt !== 1'b1; n++)
			@(posedge clk_i);
		chk("own grant", 1, 32'(own_gnt));
		chk("pins idle", 32'h1FF, 32'(gnt_n));
		op(1'b0, spa_pkg::ADDR_STATUS, 32'h0);
		chk("status", 32'h1 << spa_pkg::STAT_IGNT_POS, q);
		op(1'b1, spa_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("force idle", 0, 32'(own_gnt));
		op(1'b1, spa_pkg::ADDR_CTRL, 32'h0);
		own_req <= 1'b0;
		repeat (4) @(posedge clk_i);
		$display("own done");
	endtask
	task automatic t_ext();
		reset_to(1'b1);
		chk("pin dir", 32'h1FE, 32'(oe_n));
		own_req <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("req out", 0, 32'(gnt_n[0]));
		chk("no grant", 0, 32'(own_gnt));
		want <= 9'h001;
		for (int n = 0; n < 60 && own_gnt !== 1'b1; n++)
			@(posedge clk_i);
		chk("grant in", 1, 32'(own_gnt));
		own_req <= 1'b0;
		for (int n = 0; n < 60 && ad !== 1'b1; n++)
			@(posedge clk_i);
		chk("park", 1, 32'(ad));
		chk("par late", 0, 32'(par));
		@(posedge clk_i);
		chk("par on", 1, 32'(par));
		$display("ext done");
	endtask
	initial begin
		reset_to(1'b0);
		t_regs();
		t_lone();
		t_share();
		t_own();
		t_ext();
		print_verdict();
	end
endmodule
`default_nettype wire
